/* src/scgc_top.sv */
/*
 * clock generation and distribution: source clock mux, pll reference
 * and output gate, fast system clock and pwm fast clock dividers and
 * per-module clock gates, with an AXI4-Lite register slave.
 * assumes oscillator and pll outputs arrive as pin levels well below
 * half the bus clock rate; every derived clock leaves as a one-cycle
 * enable pulse on aclk.
 */
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// [RQ1] after reset the source clock is the internal reference clock
// [RQ2] external clock pin passes only while its input enable is set
// [RQ3] source select picks external or internal clock, switching glitch-free
// [RQ4] pll multiplies reference by 80; reference is source or source/2
// [RQ5] software changes reference divide only with pll powered down
// [RQ6] pll clock leaves only while its output gate is set
// [RQ7] fast clock source is source clock or pll clock divided by 16
// [RQ8] fast clock divider divides by 1, 2, 4 or 8
// [RQ9] fast source and divider changes take effect glitch-free
// [RQ10] pwm clock is source clock or pll clock over 1 to 32
// [RQ11] pwm clock reaches pwm only while pwm clock enable is set
// [RQ12] reset: pll off, reference undivided, fast clock source/8, pwm off
// [RQ13] debug serial clock on at reset and forced on by debugger
// [RQ14] pwm, pwm output controller, debug serial clocks not gated on standby
// [RQ15] software configures clocks in the documented order
// [RQ16] unused external, pll or pwm steps may be skipped
// [RQ17] source clock also drives the wakeup counter
// [RQ18] internal oscillator clock goes straight to the debugger baud logic
// [RQ19] in sleep cpu clock stops, module clocks follow their enables
// [RQ20] module clock gates change enable only between clock pulses
module scgc_top import scgc_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  // axi write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  // axi read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // oscillator and pll pins
  input wire logic internal_rc_osc,
  input wire logic ext_clock_in,
  input wire logic pll_clock_in,
  output logic pll_power_enable,
  output logic pll_ref_tick,
  // power state and debugger
  input wire logic debugger_connected,
  input wire logic sleep_req,
  input wire logic standby_req,
  // clock enables out
  output logic source_clock_tick,
  output logic fast_system_clock_tick,
  output logic cpu_clock_tick,
  output logic pwm_fast_clock_tick,
  output logic [NMOD-1:0] module_clock_tick,
  output logic wakeup_count_tick,
  output logic debugger_baud_tick
);

  // ************
  // state
  // ************
  typedef struct packed {
    logic [2:0] irc_s;
    logic [2:0] ext_s;
    logic [2:0] pll_s;
    logic [2:0] dbg_s;
    logic irc_l;
    logic ext_l;
    logic pll_l;
    logic dbg_l;
    logic fsel;
    logic [1:0] fdiv;
    logic ext_en;
    logic src_sel;
    logic pll_en;
    logic ref_div;
    logic pll_gate;
    logic [NMOD-1:0] mod_en;
    logic pwm_en;
    logic [2:0] pwm_sel;
    logic src_act;
    logic fsel_act;
    logic [1:0] fdiv_act;
    logic ref_ph;
    logic [3:0] p16_cnt;
    logic [2:0] fcnt;
    logic [4:0] pwm_cnt;
    logic [NMOD-1:0] gate_en;
    logic src_o;
    logic fast_o;
    logic cpu_o;
    logic pwm_o;
    logic irc_o;
    logic ref_o;
    logic [NMOD-1:0] mod_o;
    logic aw_got;
    logic [AW-1:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scgc_state_t;
  scgc_state_t r_reg, r_next;
  // ************
  // helpers
  // ************
  function automatic logic scgc_filt(input logic [2:0] s, input logic l);
    return (s[1] == s[2]) ? s[1] : l;
  endfunction : scgc_filt
  function automatic logic scgc_rise(input logic [2:0] s, input logic l);
    return (s[1] == s[2]) & s[1] & ~l;
  endfunction : scgc_rise
  function automatic logic scgc_hit(input logic [4:0] cnt, input logic [2:0] lg);
    logic [4:0] m;
    m = 5'((6'h01 << lg) - 6'h01);
    return (cnt & m) == m;
  endfunction : scgc_hit
  function automatic logic [31:0] scgc_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction : scgc_merge
  // mapped flag on top of the register word
  function automatic logic [32:0] scgc_word(input scgc_state_t s,
      input logic [AW-1:0] a);
    logic [31:0] w;
    logic ok;
    w = 32'h0;
    ok = 1'b1;
    case (a)
      A_CFG0: begin
        w[B_FSEL] = s.fsel;
        w[B_FDIV +: 2] = s.fdiv;
      end
      A_CFG1: begin
        w[B_EXTEN] = s.ext_en;
        w[B_SRCSEL] = s.src_sel;
      end
      A_PLL: begin
        w[B_PLL_POWER_ENABLE] = s.pll_en;
        w[B_PLL_REF_DIVIDE_SELECT] = s.ref_div;
        w[B_PLLGATE] = s.pll_gate;
      end
      A_MCE_LO: w = s.mod_en[31:0];
      A_MCE_HI: w[MHI-1:0] = s.mod_en[NMOD-1:32];
      A_PWMG: w[B_PWMEN] = s.pwm_en;
      A_PWMS: w[B_PWMSEL +: 3] = s.pwm_sel;
      A_STAT: w[B_ST_DBG:0] = {s.dbg_l, s.pll_en & s.pll_gate, s.fdiv_act,
          s.fsel_act, s.src_act};
      default: ok = 1'b0;
    endcase
    return {ok, w};
  endfunction : scgc_word
  // ************
  // next state
  // ************
  always_comb begin
    logic irc_t, ext_t, src_t, ref_t, pll_t, p16_t, fin_t, fast_t, pwm_t;
    logic [NMOD-1:0] eff;
    logic [32:0] wv;
    logic [32:0] rv;
    logic [31:0] wd;
    {irc_t, ext_t, src_t, ref_t, pll_t, p16_t, fin_t, fast_t, pwm_t} = '0;
    eff = '0;
    wv = '0;
    rv = '0;
    wd = '0;
    r_next = r_reg;
    // pin synchronisers
    r_next.irc_s = {r_reg.irc_s[1:0], internal_rc_osc};
    r_next.ext_s = {r_reg.ext_s[1:0], ext_clock_in};
    r_next.pll_s = {r_reg.pll_s[1:0], pll_clock_in};
    r_next.dbg_s = {r_reg.dbg_s[1:0], debugger_connected};
    r_next.irc_l = scgc_filt(r_reg.irc_s, r_reg.irc_l);
    r_next.ext_l = scgc_filt(r_reg.ext_s, r_reg.ext_l);
    r_next.pll_l = scgc_filt(r_reg.pll_s, r_reg.pll_l);
    r_next.dbg_l = scgc_filt(r_reg.dbg_s, r_reg.dbg_l);
    irc_t = scgc_rise(r_reg.irc_s, r_reg.irc_l);
    ext_t = scgc_rise(r_reg.ext_s, r_reg.ext_l) & r_reg.ext_en; // [RQ2]
    // source mux, switches on an edge of the old source, or at once from a disabled external clock
    src_t = r_reg.src_act ? ext_t : irc_t; // [RQ1]
    if ((r_reg.src_sel != r_reg.src_act) &&
        (src_t || (r_reg.src_act && !r_reg.ext_en))) begin
      r_next.src_act = r_reg.src_sel; // [RQ3]
    end
    // pll reference and output gate
    if (src_t) begin
      r_next.ref_ph = ~r_reg.ref_ph;
    end
    ref_t = src_t & (~r_reg.ref_div | r_reg.ref_ph); // [RQ4]
    pll_t = scgc_rise(r_reg.pll_s, r_reg.pll_l) & r_reg.pll_en &
        r_reg.pll_gate; // [RQ6]
    if (pll_t) begin
      r_next.p16_cnt = r_reg.p16_cnt + 4'h1;
      r_next.pwm_cnt = r_reg.pwm_cnt + 5'h01;
    end
    p16_t = pll_t & (r_reg.p16_cnt == P16_LAST); // [RQ7]
    // fast clock, new settings taken at a pulse boundary
    fin_t = r_reg.fsel_act ? p16_t : src_t; // [RQ7]
    fast_t = fin_t & scgc_hit({2'h0, r_reg.fcnt}, {1'b0, r_reg.fdiv_act}); // [RQ8]
    if (fast_t) begin
      r_next.fcnt = 3'h0;
      r_next.fsel_act = r_reg.fsel; // [RQ9]
      r_next.fdiv_act = r_reg.fdiv; // [RQ9]
    end else if (fin_t) begin
      r_next.fcnt = r_reg.fcnt + 3'h1;
    end
    // pwm clock
    if (r_reg.pwm_sel == PWMSEL_RST) begin
      pwm_t = src_t; // [RQ10]
    end else if (r_reg.pwm_sel <= PWMSEL_MAX) begin
      pwm_t = pll_t & scgc_hit(r_reg.pwm_cnt, 3'(r_reg.pwm_sel - 3'h1)); // [RQ10]
    end
    // module gates, enables move only in pulse-free cycles
    eff = r_reg.mod_en & ~({NMOD{standby_req}} & ~STBY_EXEMPT); // [RQ14]
    eff[DEBUG_SERIAL_INTERFACE_IDX] = r_reg.mod_en[DEBUG_SERIAL_INTERFACE_IDX] | r_reg.dbg_l; // [RQ13]
    if (!fast_t) begin
      r_next.gate_en = eff; // [RQ20]
    end
    r_next.src_o = src_t;
    r_next.fast_o = fast_t;
    r_next.cpu_o = fast_t & ~sleep_req & ~standby_req; // [RQ19]
    r_next.pwm_o = pwm_t & r_reg.pwm_en; // [RQ11]
    r_next.irc_o = irc_t; // [RQ18]
    r_next.ref_o = ref_t;
    r_next.mod_o = {NMOD{fast_t}} & r_reg.gate_en; // [RQ19]
    // axi write
    if (awvalid && awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_a = awaddr;
    end
    if (wvalid && wready) begin
      r_next.w_got = 1'b1;
      r_next.w_d = wdata;
      r_next.w_s = wstrb;
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_got && r_reg.w_got) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      wv = scgc_word(r_reg, r_reg.aw_a);
      wd = scgc_merge(wv[31:0], r_reg.w_d, r_reg.w_s);
      r_next.bresp = wv[32] ? RESP_OK : RESP_SLVERR;
      case (r_reg.aw_a)
        A_CFG0: begin
          r_next.fsel = wd[B_FSEL];
          r_next.fdiv = wd[B_FDIV +: 2];
        end
        A_CFG1: begin
          r_next.ext_en = wd[B_EXTEN];
          r_next.src_sel = wd[B_SRCSEL];
        end
        A_PLL: begin
          r_next.pll_en = wd[B_PLL_POWER_ENABLE];
          r_next.ref_div = wd[B_PLL_REF_DIVIDE_SELECT];
          r_next.pll_gate = wd[B_PLLGATE];
        end
        A_MCE_LO: r_next.mod_en[31:0] = wd;
        A_MCE_HI: r_next.mod_en[NMOD-1:32] = wd[MHI-1:0];
        A_PWMG: r_next.pwm_en = wd[B_PWMEN];
        A_PWMS: r_next.pwm_sel = wd[B_PWMSEL +: 3];
        default: r_next.bvalid = 1'b1;
      endcase
    end
    // axi read
    if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      rv = scgc_word(r_reg, araddr);
      r_next.rvalid = 1'b1;
      r_next.rdata = rv[31:0];
      r_next.rresp = rv[32] ? RESP_OK : RESP_SLVERR;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.fdiv <= FDIV_RST; // [RQ12]
      r_reg.fdiv_act <= FDIV_RST; // [RQ12]
      r_reg.pwm_sel <= PWMSEL_RST;
      r_reg.mod_en <= MCE_RST; // [RQ13]
      r_reg.gate_en <= MCE_RST;
    end else begin
      r_reg <= r_next;
    end
  end
  // ************
  // outputs
  // ************
  assign awready = ~r_reg.aw_got & ~r_reg.bvalid;
  assign wready = ~r_reg.w_got & ~r_reg.bvalid;
  assign arready = ~r_reg.rvalid;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign rvalid = r_reg.rvalid;
  assign rdata = r_reg.rdata;
  assign rresp = r_reg.rresp;
  assign pll_power_enable = r_reg.pll_en;
  assign pll_ref_tick = r_reg.ref_o;
  assign source_clock_tick = r_reg.src_o;
  assign fast_system_clock_tick = r_reg.fast_o;
  assign cpu_clock_tick = r_reg.cpu_o;
  assign pwm_fast_clock_tick = r_reg.pwm_o;
  assign module_clock_tick = r_reg.mod_o;
  assign wakeup_count_tick = r_reg.src_o; // [RQ17]
  assign debugger_baud_tick = r_reg.irc_o;
  // ************
  // checks
  // ************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_state_a: assert property ($rose(aresetn) |-> !r_reg.pll_en && !r_reg.ref_div // [RQ12]
      && r_reg.fdiv_act == FDIV_RST && !r_reg.pwm_en && r_reg.mod_en[DEBUG_SERIAL_INTERFACE_IDX])
    else $error("clock state wrong after reset");
  src_default_a: assert property ($rose(aresetn) ##1 (!r_reg.src_sel)[*3] // [RQ1]
      |-> !r_reg.src_act)
    else $error("source not internal after reset");
  ext_block_a: assert property (r_reg.src_act && !r_reg.ext_en |=> !source_clock_tick) // [RQ2]
    else $error("blocked external clock passed");
  pll_gate_a: assert property (r_reg.fsel_act && !r_reg.pll_gate |=> !fast_system_clock_tick) // [RQ6]
    else $error("pll clock passed a closed gate");
  pwm_off_a: assert property (!r_reg.pwm_en |=> !pwm_fast_clock_tick) // [RQ11]
    else $error("pwm clock passed while disabled");
  pwm_src_a: assert property ($past(r_reg.pwm_en) && // [RQ10]
      $past(r_reg.pwm_sel) == PWMSEL_RST && source_clock_tick |-> pwm_fast_clock_tick)
    else $error("pwm clock missed a source edge");
  gate_stable_a: assert property (!$stable(r_reg.gate_en) |-> !fast_system_clock_tick) // [RQ20]
    else $error("gate enable moved on a pulse");
  dbg_force_a: assert property (r_reg.dbg_l[*3] |-> r_reg.gate_en[DEBUG_SERIAL_INTERFACE_IDX]) // [RQ13]
    else $error("debug serial clock not forced on");
  sleep_cpu_a: assert property (sleep_req |=> !cpu_clock_tick) // [RQ19]
    else $error("cpu clock ran in sleep");
  irc_baud_a: assert property (debugger_baud_tick |-> $past(r_reg.irc_s[1]) && // [RQ18]
      !$past(r_reg.irc_l))
    else $error("baud tick without oscillator edge");
  fast_div_a: assert property (fast_system_clock_tick && r_reg.fdiv_act != 2'h0 // [RQ8]
      |-> r_reg.fcnt == 3'h0)
    else $error("divider not restarted at pulse");

endmodule : scgc_top

/* src/scgc_pkg.sv */
/*
 * constants of the system clock generation control block: register
 * offsets, field positions, reset values and module clock indices.
 * assumes a 32-bit AXI4-Lite register bus and one 100 MHz bus clock.
 */
package scgc_pkg;
  // ************
  // bus map
  // ************
  localparam int AW = 5;
  localparam logic [AW-1:0] A_CFG0 = 5'h00;
  localparam logic [AW-1:0] A_CFG1 = 5'h04;
  localparam logic [AW-1:0] A_PLL = 5'h08;
  localparam logic [AW-1:0] A_MCE_LO = 5'h0c;
  localparam logic [AW-1:0] A_MCE_HI = 5'h10;
  localparam logic [AW-1:0] A_PWMG = 5'h14;
  localparam logic [AW-1:0] A_PWMS = 5'h18;
  localparam logic [AW-1:0] A_STAT = 5'h1c;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************
  // field positions
  // ************
  localparam int B_FSEL = 0;
  localparam int B_FDIV = 1;
  localparam int B_EXTEN = 0;
  localparam int B_SRCSEL = 1;
  localparam int B_PLL_POWER_ENABLE = 0;
  localparam int B_PLL_REF_DIVIDE_SELECT = 1;
  localparam int B_PLLGATE = 2;
  localparam int B_PWMEN = 0;
  localparam int B_PWMSEL = 0;
  localparam int B_ST_DBG = 5;
  // ************
  // reset values and counts
  // ************
  localparam int NMOD = 34;
  localparam int MHI = NMOD - 32;
  localparam int DEBUG_SERIAL_INTERFACE_IDX = 10;
  localparam logic [1:0] FDIV_RST = 2'h3;
  localparam logic [2:0] PWMSEL_RST = 3'h0;
  localparam logic [2:0] PWMSEL_MAX = 3'h6;
  localparam logic [3:0] P16_LAST = 4'hf;
  localparam logic [NMOD-1:0] MCE_RST = 34'h000000400;
  // debug serial, pwm0..3 and pwm output controller 0..3
  localparam logic [NMOD-1:0] STBY_EXEMPT = 34'h1fe000400;
endpackage : scgc_pkg

/* sim/tb_top.sv */
/*
 * self-checking bench for scgc_top: register access over axi4-lite and
 * tick counts of every derived clock over fixed windows.
 * assumes bench-made pin clocks at aclk/6 or slower and one aclk domain.
 */
`timescale 1ns/1ps
module tb_top import scgc_pkg::*;;
  // ************
  // signals
  // ************
  logic aclk, aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [AW-1:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, r, q;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic internal_rc_osc = 0, ext_clock_in = 0, pll_clock_in = 0;
  logic debugger_connected = 0, sleep_req = 0, standby_req = 0;
  logic pll_power_enable, pll_ref_tick, source_clock_tick, fast_system_clock_tick;
  logic cpu_clock_tick, pwm_fast_clock_tick, wakeup_count_tick, debugger_baud_tick;
  logic [NMOD-1:0] module_clock_tick, m;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  int c[7], b[7], cm[NMOD], bm[NMOD];

  scgc_top uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .internal_rc_osc, .ext_clock_in,
    .pll_clock_in, .pll_power_enable, .pll_ref_tick, .debugger_connected,
    .sleep_req, .standby_req, .source_clock_tick, .fast_system_clock_tick,
    .cpu_clock_tick, .pwm_fast_clock_tick, .module_clock_tick,
    .wakeup_count_tick, .debugger_baud_tick);

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // ************
  // pin clocks and timeout
  // ************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    internal_rc_osc <= (cyc % 8) < 4;
    ext_clock_in <= (cyc % 10) < 5;
    pll_clock_in <= (cyc % 6) < 3;
    if (cyc == 80000) begin
      n_fail++;
      wrap_up();
    end
  end

  // tick counters, sampled away from the launch edge
  always @(negedge aclk) begin
    c[0] += source_clock_tick;
    c[1] += fast_system_clock_tick;
    c[2] += cpu_clock_tick;
    c[3] += pwm_fast_clock_tick;
    c[4] += pll_ref_tick;
    c[5] += wakeup_count_tick;
    c[6] += debugger_baud_tick;
    for (int i = 0; i < NMOD; i++) cm[i] += module_clock_tick[i];
  end

  // ************
  // tasks
  // ************
  task wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // count compare allowing one tick of window phase
  task near(input string nm, input int seen, input int exp);
    check(nm, ((seen - exp) inside {[-1:1]}) ? exp : seen, exp);
  endtask : near

  task wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    bready <= 1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 0;
        break;
      end
    end
  endtask : wr

  task rd(input logic [AW-1:0] a);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        r = rdata;
        rs = rresp;
        rready <= 0;
        break;
      end
    end
  endtask : rd

  task rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    rd(a);
    check($sformatf("reg%h", a), r, exp);
  endtask : rdc

  // settle, then count ticks over 960 cycles
  task meas();
    repeat (256) @(posedge aclk);
    b = c;
    bm = cm;
    repeat (960) @(posedge aclk);
    for (int i = 0; i < 7; i++) b[i] = c[i] - b[i];
    for (int i = 0; i < NMOD; i++) bm[i] = cm[i] - bm[i];
  endtask : meas

  task mods(input logic [NMOD-1:0] en);
    for (int i = 0; i < NMOD; i++) near($sformatf("mod%0d", i), bm[i], en[i] ? 120 : 0);
  endtask : mods

  // ************
  // main sequence
  // ************
  initial begin
    c = '{default: 0};
    cm = '{default: 0};
    void'($urandom(88573));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdc(A_CFG0, {29'h0, FDIV_RST, 1'b0});
    rdc(A_CFG1, 32'h0);
    rdc(A_PLL, 32'h0);
    rdc(A_MCE_LO, MCE_RST[31:0]);
    rdc(A_MCE_HI, {30'h0, MCE_RST[NMOD-1:32]});
    rdc(A_PWMG, 32'h0);
    rdc(A_PWMS, {29'h0, PWMSEL_RST});
    check("pll_en", pll_power_enable, 32'h0);
    rd(5'h03);
    check("rresp", rs, RESP_SLVERR);
    check("rdata", r, 32'h0);
    wr(5'h06, 32'h1);
    check("bresp", rs, RESP_SLVERR);
    wr(A_MCE_LO, 32'h0);
    wr(A_MCE_LO, 32'hffffffff, 4'h2);
    rdc(A_MCE_LO, 32'h0000ff00);
    for (int k = 0; k < 8; k++) begin
      q = $urandom;
      wr(A_MCE_HI, q);
      rdc(A_MCE_HI, q & 32'h3);
      wr(A_PWMS, q);
      rdc(A_PWMS, q & 32'h7);
    end
    wr(A_MCE_LO, MCE_RST[31:0]);
    wr(A_MCE_HI, 32'h0);
    wr(A_PWMS, 32'h0);
    meas();
    near("src", b[0], 120);
    near("baud", b[6], 120);
    near("wake", b[5], 120);
    near("fast", b[1], 15);
    near("cpu", b[2], 15);
    check("pwm", b[3], 32'h0);
    near("mod10", bm[10], 15);
    check("mod0", bm[0], 32'h0);
    for (int d = 0; d < 4; d++) begin
      wr(A_CFG0, d << 1);
      meas();
      near("fast", b[1], 120 >> d);
    end
    wr(A_CFG1, 32'h1);
    meas();
    near("src", b[0], 120);
    wr(A_CFG1, 32'h3);
    meas();
    near("src", b[0], 96);
    near("baud", b[6], 120);
    near("wake", b[5], 96);
    wr(A_CFG1, 32'h2);
    meas();
    check("src", b[0], 32'h0);
    wr(A_CFG1, 32'h0);
    meas();
    near("src", b[0], 120);
    wr(A_PLL, 32'h1);
    check("pll_en", pll_power_enable, 32'h1);
    meas();
    near("ref", b[4], 120);
    wr(A_PLL, 32'h0);
    wr(A_PLL, 32'h2);
    wr(A_PLL, 32'h3);
    meas();
    near("ref", b[4], 60);
    wr(A_PWMS, 32'h1);
    wr(A_PWMG, 32'h1);
    meas();
    check("pwm", b[3], 32'h0);
    wr(A_PWMG, 32'h0);
    wr(A_PLL, 32'h7);
    for (int s = 1; s < 7; s++) begin
      wr(A_PWMS, s);
      wr(A_PWMG, 32'h1);
      meas();
      near("pwm", b[3], 160 >> (s - 1));
      wr(A_PWMG, 32'h0);
    end
    meas();
    check("pwm", b[3], 32'h0);
    wr(A_PWMS, 32'h7);
    wr(A_PWMG, 32'h1);
    meas();
    check("pwm", b[3], 32'h0);
    wr(A_PWMG, 32'h0);
    wr(A_PWMS, 32'h0);
    wr(A_PWMG, 32'h1);
    meas();
    near("pwm", b[3], 120);
    wr(A_PWMG, 32'h0);
    wr(A_CFG0, 32'h1);
    meas();
    near("fast", b[1], 10);
    wr(A_PLL, 32'h3);
    meas();
    check("fast", b[1], 32'h0);
    wr(A_PLL, 32'h7);
    wr(A_CFG0, 32'h3);
    meas();
    near("fast", b[1], 5);
    wr(A_CFG0, 32'h0);
    meas();
    near("fast", b[1], 120);
    m = NMOD'({$urandom, $urandom});
    wr(A_MCE_LO, m[31:0]);
    wr(A_MCE_HI, {30'h0, m[33:32]});
    meas();
    mods(m);
    standby_req <= 1;
    meas();
    mods(m & STBY_EXEMPT);
    check("cpu", b[2], 32'h0);
    standby_req <= 0;
    sleep_req <= 1;
    meas();
    mods(m);
    check("cpu", b[2], 32'h0);
    sleep_req <= 0;
    wr(A_MCE_LO, 32'h0);
    wr(A_MCE_HI, 32'h0);
    debugger_connected <= 1;
    meas();
    near("mod10", bm[10], 120);
    rd(A_STAT);
    check("dbg", r[B_ST_DBG], 1'b1);
    debugger_connected <= 0;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdc(A_CFG0, {29'h0, FDIV_RST, 1'b0});
    wrap_up();
  end
endmodule : tb_top
